// File: acr_pkg.sv
// constants for the converter misc, serializer and calibration register bank
package acr_pkg;
    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] ANALOG_MISC_CONTROL_OFS            = 12'h033;
    localparam logic [11:0] ANALOG_INPUT_CLAMP_CONTROL_OFS     = 12'h034;
    localparam logic [11:0] SERIAL_DRIVER_EMPHASIS_OFS         = 12'h040;
    localparam logic [11:0] CALIBRATION_CONFIG_FIRST_OFS       = 12'h050;
    localparam logic [11:0] CALIBRATION_CONFIG_SECOND_OFS      = 12'h051;
    localparam logic [11:0] RESERVED_CAL_52_OFS                = 12'h052;
    localparam logic [11:0] RESERVED_CAL_53_OFS                = 12'h053;
    localparam logic [11:0] RESERVED_CAL_54_OFS                = 12'h054;
    localparam logic [11:0] RESERVED_CAL_55_OFS                = 12'h055;
    localparam logic [11:0] RESERVED_CAL_56_OFS                = 12'h056;
    localparam logic [11:0] BACKGROUND_CALIBRATION_CONTROL_OFS = 12'h057;
    localparam logic [11:0] TEST_PATTERN_OVERRANGE_ENABLE_OFS  = 12'h058;
    localparam logic [11:0] RESERVED_CAL_59_OFS                = 12'h059;
    localparam logic [11:0] CALIBRATION_VECTOR_PORT_OFS        = 12'h05A;
    localparam logic [11:0] CALIBRATION_STATE_REPORT_OFS       = 12'h05B;
    localparam logic [11:0] RESERVED_CAL_5C_OFS                = 12'h05C;
    localparam logic [11:0] RESERVED_CAL_5F_OFS                = 12'h05F;
    localparam logic [11:0] SAMPLING_TIMING_CALIBRATION_OFS    = 12'h066;
    localparam logic [11:0] RESERVED_CAL_67_OFS                = 12'h067;
    localparam logic [11:0] RESERVED_CAL_6A_OFS                = 12'h06A;
    localparam logic [11:0] RESERVED_CAL_6B_OFS                = 12'h06B;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ANALOG_MISC_CONTROL_RST            = 8'hC3;
    localparam logic [7:0] ANALOG_INPUT_CLAMP_CONTROL_RST     = 8'h2F;
    localparam logic [7:0] SERIAL_DRIVER_EMPHASIS_RST         = 8'h04;
    localparam logic [7:0] CALIBRATION_CONFIG_FIRST_RST       = 8'h06;
    localparam logic [7:0] CALIBRATION_CONFIG_SECOND_RST      = 8'hF4;
    localparam logic [7:0] RESERVED_CAL_52_RST                = 8'h00;
    localparam logic [7:0] RESERVED_CAL_53_RST                = 8'h5C;
    localparam logic [7:0] RESERVED_CAL_54_RST                = 8'h1C;
    localparam logic [7:0] RESERVED_CAL_55_RST                = 8'h92;
    localparam logic [7:0] RESERVED_CAL_56_RST                = 8'h20;
    localparam logic [7:0] BACKGROUND_CALIBRATION_CONTROL_RST = 8'h10;
    localparam logic [7:0] TEST_PATTERN_OVERRANGE_ENABLE_RST  = 8'h00;
    localparam logic [7:0] RESERVED_CAL_59_RST                = 8'h00;
    localparam logic [7:0] CALIBRATION_VECTOR_PORT_RST        = 8'h00;
    localparam logic [7:0] RESERVED_CAL_5C_RST                = 8'h00;
    localparam logic [7:0] RESERVED_CAL_5F_RST                = 8'h00;
    localparam logic [7:0] SAMPLING_TIMING_CALIBRATION_RST    = 8'h02;
    localparam logic [7:0] RESERVED_CAL_67_RST                = 8'h01;
    localparam logic [7:0] RESERVED_CAL_6A_RST                = 8'h00;
    localparam logic [7:0] RESERVED_CAL_6B_RST                = 8'h20;
    // answer for addresses with no defined content
    localparam logic [7:0] UNDEFINED_READ_VAL                 = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned SYNC_RECEIVER_POWERDOWN_BIT = 2;
    localparam int unsigned INPUT_CLAMP_ENABLE_BIT      = 5;
    localparam int unsigned EMPHASIS_LSB                = 0;
    localparam int unsigned EMPHASIS_W                  = 4;
    localparam int unsigned EXTERNAL_MARKER_ENABLE_BIT  = 5;
    localparam int unsigned VECTOR_ACCESS_ENABLE_BIT    = 4;
    localparam int unsigned FOREGROUND_CAL_TRIGGER_BIT  = 3;
    localparam int unsigned BACKGROUND_CAL_RUN_BIT      = 1;
    localparam int unsigned BACKGROUND_CAL_ENABLE_BIT   = 0;
endpackage : acr_pkg

// File: acr_regs.sv
// register bank: analog misc, input clamp, serializer emphasis, calibration region
//
// Behaviour
// RL1 - bit 2 set powers down sync receiver
// RL2 - software keeps receiver on while sync/marker used
// RL3 - clamp bit 5 enables clamp, resets one
// RL4 - clamp register at 0x034, resets 0x2F
// RL5 - emphasis strength in bits 3-0, resets four
// RL6 - software sets emphasis for trace loss
// RL7 - serializer register 0x040 reset 0x04; 0x041-0x04F reserved
// RL8 - 0x050 resets 0x06 with marker/vector/trigger bits
// RL9 - 0x051, 0x057, 0x066 placed with resets
// RL10 - 0x058, 0x05A zero; 0x05B status undefined reset
// RL11 - analog misc at 0x033 resets 0xC3
// RL12 - reserved fields store and read back
module acr_regs
    import acr_pkg::*;
(
    input  wire logic        core_clk,                 // 125 MHz register clock
    input  wire logic        reset,                    // synchronous, active high
    input  wire logic [11:0] reg_addr,                 // register offset
    input  wire logic [7:0]  reg_wdata,                // write data
    input  wire logic        reg_wr,                   // write strobe
    input  wire logic        reg_rd,                   // read strobe
    output logic      [7:0]  reg_rdata,                // read data, cycle after strobe
    input  wire logic [7:0]  cal_status,               // calibration engine status, async
    output logic             sync_receiver_powerdown,  // sync receiver power down
    output logic             input_clamp_enable,       // analog clamp enable
    output logic      [3:0]  emphasis_strength,        // serializer pre-emphasis
    output logic             external_marker_enable,   // external_marker_input capture enable
    output logic             vector_access_enable,     // calibration vector access enable
    output logic             foreground_cal_trigger,   // one-cycle calibration start pulse
    output logic             background_cal_enable,    // background calibration enable
    output logic             background_cal_run        // background calibration run/pause
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] misc_q, clamp_q, emph_q, cfg0_q, cfg1_q, back_q, pat_q, vec_q, tcal_q;
    logic [7:0] r52_q, r53_q, r54_q, r55_q, r56_q, r59_q, r5c_q, r5f_q, r67_q, r6a_q, r6b_q;
    logic [7:0] stat_meta_q, stat_q;
    logic       trig_q;
    logic       wr_cfg0;

    assign wr_cfg0 = reg_wr && (reg_addr == CALIBRATION_CONFIG_FIRST_OFS);

    // ------------------------------------------------------------
    // named registers
    // ------------------------------------------------------------
    // full-byte storage keeps reserved bits readable as written
    always_ff @(posedge core_clk) begin
        if (reset) begin
            misc_q  <= ANALOG_MISC_CONTROL_RST;                      // RL11
            clamp_q <= ANALOG_INPUT_CLAMP_CONTROL_RST;               // RL4
            emph_q  <= SERIAL_DRIVER_EMPHASIS_RST;                   // RL7
            cfg1_q  <= CALIBRATION_CONFIG_SECOND_RST;                // RL9
            back_q  <= BACKGROUND_CALIBRATION_CONTROL_RST;           // RL9
            pat_q   <= TEST_PATTERN_OVERRANGE_ENABLE_RST;            // RL10
            vec_q   <= CALIBRATION_VECTOR_PORT_RST;                  // RL10
            tcal_q  <= SAMPLING_TIMING_CALIBRATION_RST;              // RL9
        end else if (reg_wr) begin
            case (reg_addr)
                ANALOG_MISC_CONTROL_OFS:            misc_q  <= reg_wdata; // RL1
                ANALOG_INPUT_CLAMP_CONTROL_OFS:     clamp_q <= reg_wdata; // RL3
                SERIAL_DRIVER_EMPHASIS_OFS:         emph_q  <= reg_wdata; // RL5
                CALIBRATION_CONFIG_SECOND_OFS:      cfg1_q  <= reg_wdata;
                BACKGROUND_CALIBRATION_CONTROL_OFS: back_q  <= reg_wdata;
                TEST_PATTERN_OVERRANGE_ENABLE_OFS:  pat_q   <= reg_wdata;
                SAMPLING_TIMING_CALIBRATION_OFS:    tcal_q  <= reg_wdata;
                CALIBRATION_VECTOR_PORT_OFS: begin
                    // vector port only takes writes while access is enabled
                    if (cfg0_q[VECTOR_ACCESS_ENABLE_BIT]) begin
                        vec_q <= reg_wdata;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // reserved registers with defined resets
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            r52_q <= RESERVED_CAL_52_RST;
            r53_q <= RESERVED_CAL_53_RST;
            r54_q <= RESERVED_CAL_54_RST;
            r55_q <= RESERVED_CAL_55_RST;
            r56_q <= RESERVED_CAL_56_RST;
            r59_q <= RESERVED_CAL_59_RST;
            r5c_q <= RESERVED_CAL_5C_RST;
            r5f_q <= RESERVED_CAL_5F_RST;
            r67_q <= RESERVED_CAL_67_RST;
            r6a_q <= RESERVED_CAL_6A_RST;
            r6b_q <= RESERVED_CAL_6B_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                RESERVED_CAL_52_OFS: r52_q <= reg_wdata; // RL12
                RESERVED_CAL_53_OFS: r53_q <= reg_wdata; // RL12
                RESERVED_CAL_54_OFS: r54_q <= reg_wdata; // RL12
                RESERVED_CAL_55_OFS: r55_q <= reg_wdata; // RL12
                RESERVED_CAL_56_OFS: r56_q <= reg_wdata; // RL12
                RESERVED_CAL_59_OFS: r59_q <= reg_wdata; // RL12
                RESERVED_CAL_5C_OFS: r5c_q <= reg_wdata; // RL12
                RESERVED_CAL_5F_OFS: r5f_q <= reg_wdata; // RL12
                RESERVED_CAL_67_OFS: r67_q <= reg_wdata; // RL12
                RESERVED_CAL_6A_OFS: r6a_q <= reg_wdata; // RL12
                RESERVED_CAL_6B_OFS: r6b_q <= reg_wdata; // RL12
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // first calibration config with self-clearing trigger
    // ------------------------------------------------------------
    // trigger bit is never stored: it reads back zero at any time
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cfg0_q <= CALIBRATION_CONFIG_FIRST_RST;                  // RL8
            trig_q <= 1'b0;
        end else begin
            trig_q <= wr_cfg0 && reg_wdata[FOREGROUND_CAL_TRIGGER_BIT]; // RL8
            if (wr_cfg0) begin
                cfg0_q <= reg_wdata & ~(8'h01 << FOREGROUND_CAL_TRIGGER_BIT);
            end
        end
    end

    // ------------------------------------------------------------
    // status sampling
    // ------------------------------------------------------------
    // status comes from the calibration engine on another timing path
    always_ff @(posedge core_clk) begin
        if (reset) begin
            stat_meta_q <= 8'h00;
            stat_q      <= 8'h00;
        end else begin
            stat_meta_q <= cal_status;
            stat_q      <= stat_meta_q;                              // RL10
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // unlisted and undefined addresses answer a fixed value, never stall
    always_ff @(posedge core_clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ANALOG_MISC_CONTROL_OFS:            reg_rdata <= misc_q;
                ANALOG_INPUT_CLAMP_CONTROL_OFS:     reg_rdata <= clamp_q;
                SERIAL_DRIVER_EMPHASIS_OFS:         reg_rdata <= emph_q;
                CALIBRATION_CONFIG_FIRST_OFS:       reg_rdata <= cfg0_q;
                CALIBRATION_CONFIG_SECOND_OFS:      reg_rdata <= cfg1_q;
                RESERVED_CAL_52_OFS:                reg_rdata <= r52_q;
                RESERVED_CAL_53_OFS:                reg_rdata <= r53_q;
                RESERVED_CAL_54_OFS:                reg_rdata <= r54_q;
                RESERVED_CAL_55_OFS:                reg_rdata <= r55_q;
                RESERVED_CAL_56_OFS:                reg_rdata <= r56_q;
                BACKGROUND_CALIBRATION_CONTROL_OFS: reg_rdata <= back_q;
                TEST_PATTERN_OVERRANGE_ENABLE_OFS:  reg_rdata <= pat_q;
                RESERVED_CAL_59_OFS:                reg_rdata <= r59_q;
                CALIBRATION_VECTOR_PORT_OFS:        reg_rdata <= vec_q;
                CALIBRATION_STATE_REPORT_OFS:       reg_rdata <= stat_q;
                RESERVED_CAL_5C_OFS:                reg_rdata <= r5c_q;
                RESERVED_CAL_5F_OFS:                reg_rdata <= r5f_q;
                SAMPLING_TIMING_CALIBRATION_OFS:    reg_rdata <= tcal_q;
                RESERVED_CAL_67_OFS:                reg_rdata <= r67_q;
                RESERVED_CAL_6A_OFS:                reg_rdata <= r6a_q;
                RESERVED_CAL_6B_OFS:                reg_rdata <= r6b_q;
                default:                            reg_rdata <= UNDEFINED_READ_VAL; // RL7
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // control outputs, registered
    // ------------------------------------------------------------
    // one cycle behind the storage so every output leaves a flip-flop
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync_receiver_powerdown <= ANALOG_MISC_CONTROL_RST[SYNC_RECEIVER_POWERDOWN_BIT];
            input_clamp_enable      <= ANALOG_INPUT_CLAMP_CONTROL_RST[INPUT_CLAMP_ENABLE_BIT];
            emphasis_strength       <= SERIAL_DRIVER_EMPHASIS_RST[EMPHASIS_LSB +: EMPHASIS_W];
            external_marker_enable  <= CALIBRATION_CONFIG_FIRST_RST[EXTERNAL_MARKER_ENABLE_BIT];
            vector_access_enable    <= CALIBRATION_CONFIG_FIRST_RST[VECTOR_ACCESS_ENABLE_BIT];
            foreground_cal_trigger  <= 1'b0;
            background_cal_enable   <= BACKGROUND_CALIBRATION_CONTROL_RST[BACKGROUND_CAL_ENABLE_BIT];
            background_cal_run      <= BACKGROUND_CALIBRATION_CONTROL_RST[BACKGROUND_CAL_RUN_BIT];
        end else begin
            sync_receiver_powerdown <= misc_q[SYNC_RECEIVER_POWERDOWN_BIT];       // RL1
            input_clamp_enable      <= clamp_q[INPUT_CLAMP_ENABLE_BIT];           // RL3
            emphasis_strength       <= emph_q[EMPHASIS_LSB +: EMPHASIS_W];        // RL5
            external_marker_enable  <= cfg0_q[EXTERNAL_MARKER_ENABLE_BIT];        // RL8
            vector_access_enable    <= cfg0_q[VECTOR_ACCESS_ENABLE_BIT];          // RL8
            foreground_cal_trigger  <= trig_q;                                    // RL8
            background_cal_enable   <= back_q[BACKGROUND_CAL_ENABLE_BIT];
            background_cal_run      <= back_q[BACKGROUND_CAL_RUN_BIT];
        end
    end
endmodule : acr_regs

// File: acr_regs_checker.sv
// concurrent checks on the converter register bank ports
module acr_regs_checker (
    input wire logic        core_clk,                 // clock
    input wire logic        reset,                    // sync reset
    input wire logic [11:0] reg_addr,                 // offset
    input wire logic [7:0]  reg_wdata,                // write data
    input wire logic        reg_wr,                   // write strobe
    input wire logic        reg_rd,                   // read strobe
    input wire logic [7:0]  reg_rdata,                // read data
    input wire logic [7:0]  cal_status,               // status in
    input wire logic        sync_receiver_powerdown,  // sync rx off
    input wire logic        input_clamp_enable,       // clamp on
    input wire logic [3:0]  emphasis_strength,        // emphasis
    input wire logic        external_marker_enable,   // marker on
    input wire logic        vector_access_enable,     // vector access
    input wire logic        foreground_cal_trigger,   // cal pulse
    input wire logic        background_cal_enable,    // bg enable
    input wire logic        background_cal_run        // bg run
);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    // changes caused by reset itself are excluded through the past reset level
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    AST_PD_SET: assert property (reg_wr && reg_addr == 12'h033 |->
        ##2 sync_receiver_powerdown == $past(reg_wdata[2], 2))
        else $error("powerdown not following write");
    AST_PD_CAUSE: assert property ($changed(sync_receiver_powerdown) && !$past(reset) |->
        $past(reg_wr, 2) && $past(reg_addr, 2) == 12'h033)
        else $error("powerdown changed without write");
    AST_CLAMP_SET: assert property (reg_wr && reg_addr == 12'h034 |->
        ##2 input_clamp_enable == $past(reg_wdata[5], 2))
        else $error("clamp not following write");
    AST_EMPH_SET: assert property (reg_wr && reg_addr == 12'h040 |->
        ##2 emphasis_strength == $past(reg_wdata[3:0], 2))
        else $error("emphasis not following write");
    AST_EMPH_CAUSE: assert property ($changed(emphasis_strength) && !$past(reset) |->
        $past(reg_wr, 2) && $past(reg_addr, 2) == 12'h040)
        else $error("emphasis changed without write");
    AST_CFG_BITS: assert property (reg_wr && reg_addr == 12'h050 |->
        ##2 {external_marker_enable, vector_access_enable} == $past(reg_wdata[5:4], 2))
        else $error("marker or vector enable wrong");
    AST_TRIG_FIRE: assert property (reg_wr && reg_addr == 12'h050 && reg_wdata[3] |->
        ##2 foreground_cal_trigger)
        else $error("calibration trigger missing");
    // back-to-back trigger writes legally give back-to-back pulses
    AST_TRIG_PULSE: assert property (foreground_cal_trigger |=> !foreground_cal_trigger ||
        ($past(reg_wr, 2) && $past(reg_addr, 2) == 12'h050 && $past(reg_wdata[3], 2)))
        else $error("calibration trigger too long");
    AST_TRIG_CAUSE: assert property (foreground_cal_trigger |->
        $past(reg_wr, 2) && $past(reg_addr, 2) == 12'h050 && $past(reg_wdata[3], 2))
        else $error("calibration trigger without write");
    AST_BG_SET: assert property (reg_wr && reg_addr == 12'h057 |->
        ##2 {background_cal_run, background_cal_enable} == $past(reg_wdata[1:0], 2))
        else $error("background control wrong");

    // main scenarios
    COV_TRIG: cover property (foreground_cal_trigger);
    COV_READ: cover property (reg_rd ##1 reg_rdata != 8'h00);
    COV_PD: cover property (sync_receiver_powerdown);
endmodule : acr_regs_checker

bind acr_regs acr_regs_checker u_acr_regs_checker (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .cal_status, .sync_receiver_powerdown, .input_clamp_enable, .emphasis_strength,
    .external_marker_enable, .vector_access_enable, .foreground_cal_trigger, .background_cal_enable,
    .background_cal_run);

// File: testbench.sv
// self-checking bench for the converter register bank
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, reset, reg_wr, reg_rd;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, cal_status;
    logic        sync_receiver_powerdown, input_clamp_enable, external_marker_enable;
    logic        vector_access_enable, foreground_cal_trigger, background_cal_enable, background_cal_run;
    logic [3:0]  emphasis_strength;
    int          errors = 0;
    int          checked = 0;
    int          pulses = 0;
    // offset and reset value pairs
    logic [19:0] rst_tab [20] = '{20'h033C3, 20'h0342F, 20'h04004, 20'h05006, 20'h051F4, 20'h05200, 20'h0535C,
        20'h0541C, 20'h05592, 20'h05620, 20'h05710, 20'h05800, 20'h05900, 20'h05A00, 20'h05C00, 20'h05F00,
        20'h06602, 20'h06701, 20'h06A00, 20'h06B20};

    acr_regs u_acr_regs (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cal_status(cal_status),
        .sync_receiver_powerdown(sync_receiver_powerdown), .input_clamp_enable(input_clamp_enable),
        .emphasis_strength(emphasis_strength), .external_marker_enable(external_marker_enable),
        .vector_access_enable(vector_access_enable), .foreground_cal_trigger(foreground_cal_trigger),
        .background_cal_enable(background_cal_enable), .background_cal_run(background_cal_run));

    // ------------------------------------------------------------
    // clock, tasks and verdict
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one-cycle write; a read or the caller drops the strobe, a next write keeps it high
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
    endtask : wr

    // data is sampled mid-cycle, where it stands for one cycle only
    task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk(reg_rdata, exp);
    endtask : rdc

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict

    // watchdog well beyond the hundred or so cycles the tests need
    initial begin
        #40000;
        errors++;
        $display("watchdog expired");
        give_verdict();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 12'h000;
        reg_wdata = 8'h00;
        cal_status = 8'h3C;
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        foreach (rst_tab[i]) rdc(rst_tab[i][19:8], rst_tab[i][7:0]);
        chk({7'h00, sync_receiver_powerdown}, 8'h00);
        chk({7'h00, input_clamp_enable}, 8'h01);
        chk({4'h0, emphasis_strength}, 8'h04);
        chk({6'h00, external_marker_enable, vector_access_enable}, 8'h00);
        chk({6'h00, background_cal_run, background_cal_enable}, 8'h00);
        rdc(12'h05B, 8'h3C);
        $display("reset values done");
        // back-to-back writes, reserved bits must survive
        wr(12'h033, 8'hC7);
        wr(12'h034, 8'h0F);
        wr(12'h040, 8'h5A);
        wr(12'h057, 8'h13);
        wr(12'h053, 8'hA5);
        rdc(12'h033, 8'hC7);
        rdc(12'h034, 8'h0F);
        rdc(12'h040, 8'h5A);
        rdc(12'h057, 8'h13);
        rdc(12'h053, 8'hA5);
        chk({7'h00, sync_receiver_powerdown}, 8'h01);
        chk({7'h00, input_clamp_enable}, 8'h00);
        chk({4'h0, emphasis_strength}, 8'h0A);
        chk({6'h00, background_cal_run, background_cal_enable}, 8'h03);
        $display("write readback done");
        // trigger must be one pulse and read back as zero
        // receiver powered again before the marker capture is enabled
        wr(12'h033, 8'hC3);
        wr(12'h050, 8'h3E);
        repeat (6) begin
            @(posedge core_clk);
            reg_wr <= 1'b0;
            @(negedge core_clk);
            if (foreground_cal_trigger === 1'b1) pulses++;
        end
        chk(8'(pulses), 8'h01);
        rdc(12'h050, 8'h36);
        chk({6'h00, external_marker_enable, vector_access_enable}, 8'h03);
        $display("calibration trigger done");
        // vector port accepts writes only while access is enabled
        wr(12'h05A, 8'h77);
        wr(12'h050, 8'h06);
        wr(12'h05A, 8'h11);
        wr(12'h058, 8'h81);
        rdc(12'h05A, 8'h77);
        rdc(12'h058, 8'h81);
        $display("vector port done");
        // undefined and read-only places drop writes; 0x066 stores its write
        wr(12'h045, 8'hFF);
        wr(12'h05B, 8'hFF);
        wr(12'h066, 8'h55);
        rdc(12'h045, 8'h00);
        rdc(12'h066, 8'h55);
        // status passes two flops, so the read starts two edges later
        @(posedge core_clk);
        cal_status <= 8'hA1;
        repeat (2) @(posedge core_clk);
        rdc(12'h05B, 8'hA1);
        $display("unmapped and status done");
        // reset in mid-run restores defaults
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        rdc(12'h033, 8'hC3);
        rdc(12'h040, 8'h04);
        chk({7'h00, sync_receiver_powerdown}, 8'h00);
        chk({7'h00, input_clamp_enable}, 8'h01);
        chk({4'h0, emphasis_strength}, 8'h04);
        $display("second reset done");
        give_verdict();
    end
endmodule : testbench
